// file: hw/light_cfg_pkg.sv
// Constants of the light sensor operation-control block: field layout,
// reset values and conversion timing at the 250 MHz core clock.
// Assumes a register port that presents one decoded access per cycle.
//
// Functional notes
// - 16-bit control word at 01h, resets C810h.
// - Control write aborts a running conversion immediately.
// - New conversion starts if written mode asks.
// - Bits 15-12 pick range, exponent coding.
// - Range code 1100b means automatic range selection.
// - Bit 11: 0 is 100 ms, 1 is 800 ms.
// - Short conversions lose resolution on low ranges.
// - Result coding unchanged by conversion length.
// - Bits 10-9: off, single-shot, continuous, continuous.
// - Single-shot reads 01b, then clears to 00b.
// - Entering shutdown keeps the flags unchanged.
// - Flag bits 8-5 read-only, reset to zero.
// - Done flag sets at end, clears on a read or on a write that starts a conversion.
// - Auto overflow raises range, restarts, flags at top.
// - Limit flags need 1, 2, 4 or 8 consecutive exceeding results, by persist_count.
package light_cfg_pkg;

    // ------------------------------------------------------------------
    // Register map and field layout
    // ------------------------------------------------------------------
    localparam logic [7:0]  CFG_ADDR      = 8'h01;
    localparam logic [15:0] CFG_RESET     = 16'hc810;
    localparam int          RN_LSB        = 12;
    localparam int          CT_BIT        = 11;
    localparam int          MODE_LSB      = 9;
    localparam int          OVF_BIT       = 8;
    localparam int          CRF_BIT       = 7;
    localparam int          FH_BIT        = 6;
    localparam int          FL_BIT        = 5;
    localparam int          LATCH_BIT     = 4;
    localparam int          POL_BIT       = 3;
    localparam int          ME_BIT        = 2;
    localparam int          FC_LSB        = 0;

    // ------------------------------------------------------------------
    // Field codes and reset values
    // ------------------------------------------------------------------
    localparam logic [3:0]  RANGE_RESET   = 4'hc;
    localparam logic [3:0]  RANGE_AUTO    = 4'hc;
    localparam logic [3:0]  RANGE_MAX     = 4'hb;
    localparam logic [3:0]  RANGE_HALF    = 4'h5;
    localparam logic        CT_RESET      = 1'b1;
    localparam logic [1:0]  MODE_OFF      = 2'h0;
    localparam logic [1:0]  MODE_SINGLE   = 2'h1;
    localparam logic        LATCH_RESET   = 1'b1;

    // ------------------------------------------------------------------
    // Conversion timing
    // ------------------------------------------------------------------
    localparam int unsigned CLK_KHZ       = 250000;
    localparam int unsigned CONV_SHORT_MS = 100;
    localparam int unsigned CONV_LONG_MS  = 800;
    localparam int unsigned CONV_SHORT_CYC = CONV_SHORT_MS * CLK_KHZ;
    localparam int unsigned CONV_LONG_CYC  = CONV_LONG_MS * CLK_KHZ;
    localparam int          CNT_W         = 28;

endpackage

// file: hw/fault_persist.sv
// Consecutive-result filter for one limit comparison.
// Assumes meas_end is a one-cycle pulse at each finished conversion.
`timescale 1ns/1ps
`default_nettype none
module fault_persist
    import light_cfg_pkg::*;
(
    // Clock and reset
    input  wire logic       core_clk,
    input  wire logic       sys_rst,
    // Measurement stream
    input  wire logic       meas_end,
    input  wire logic       exceed,
    input  wire logic [1:0] persist_count,
    // Result
    output logic            hit_r
);
    logic [3:0] run_r;
    logic [3:0] need;

    // Codes 0..3 ask for 1, 2, 4 and 8 consecutive results.
    assign need = 4'h1 << persist_count;

    // ------------------------------------------------------------------
    // Run length and flag
    // ------------------------------------------------------------------
    always_ff @(posedge core_clk or posedge sys_rst) begin
        if (sys_rst) begin
            run_r <= 4'h0;
            hit_r <= 1'b0;
        end else if (meas_end) begin
            if (!exceed) begin
                run_r <= 4'h0;
                hit_r <= 1'b0;
            end else begin
                if (run_r < need) begin
                    run_r <= run_r + 4'h1;
                end
                hit_r <= (run_r + 4'h1 >= need);
            end
        end
    end

endmodule
`default_nettype wire

// file: hw/light_cfg_ctrl.sv
// Operation-control block of the light sensor: control word, conversion
// sequencing, automatic ranging and the status flags.
// Assumes the serial front end decodes one register access per cycle and
// that limit comparison results are valid when a conversion ends.
`timescale 1ns/1ps
`default_nettype none
module light_cfg_ctrl
    import light_cfg_pkg::*;
#(
    parameter int unsigned SHORT_CYC = CONV_SHORT_CYC,
    parameter int unsigned LONG_CYC  = CONV_LONG_CYC
)(
    // Clock and reset
    input  wire logic        core_clk,
    input  wire logic        sys_rst,
    // Register access from the serial front end
    input  wire logic [7:0]  reg_addr,
    input  wire logic        reg_wr,
    input  wire logic        reg_rd,
    input  wire logic [15:0] reg_wdata,
    output logic      [15:0] reg_rdata_r,
    // Converter front end
    input  wire logic        adc_overload,
    input  wire logic        above_limit_in,
    input  wire logic        below_limit_in,
    // Conversion status
    output logic             conv_busy_r,
    output logic             conv_end_r,
    output logic      [3:0]  conv_range_r,
    output logic      [3:0]  result_exp_r,
    output logic      [1:0]  res_loss_r,
    // Side settings for the interrupt logic
    output logic             latch_mode_r,
    output logic             irq_polarity_r
);

    typedef enum logic {st_off, st_conv} conv_state_e;

    conv_state_e      state_r;
    logic [3:0]       range_select_r;
    logic             conv_length_sel_r;
    logic [1:0]       mode_r;
    logic             exponent_hide_r;
    logic [1:0]       persist_count_r;
    logic             overrange_flag_r;
    logic             conv_done_flag_r;
    logic [CNT_W-1:0] cnt_r;
    logic             ovl_seen_r;
    logic             ovl_meta_r;
    logic             ovl_sync_r;
    logic             above_limit_flag;
    logic             below_limit_flag;
    logic             wr_cfg;
    logic             rd_cfg;
    logic             auto_mode;
    logic             bump;
    logic             conv_end;
    logic [CNT_W-1:0] conv_last;
    logic [15:0]      cfg_word;

    // ------------------------------------------------------------------
    // Decode
    // ------------------------------------------------------------------
    assign wr_cfg    = reg_wr && (reg_addr == CFG_ADDR);
    assign rd_cfg    = reg_rd && (reg_addr == CFG_ADDR);
    // Reserved codes above auto are treated as auto so ranging stays sane.
    assign auto_mode = (range_select_r >= RANGE_AUTO);
    assign conv_last = conv_length_sel_r ? CNT_W'(LONG_CYC - 1)
                                         : CNT_W'(SHORT_CYC - 1);
    assign bump      = (state_r == st_conv) && !wr_cfg && auto_mode
                       && ovl_sync_r && (conv_range_r < RANGE_MAX);
    assign conv_end  = (state_r == st_conv) && !wr_cfg && !bump
                       && (cnt_r == conv_last);

    always_comb begin
        cfg_word                        = 16'h0000;
        cfg_word[RN_LSB +: 4]           = range_select_r;
        cfg_word[CT_BIT]                = conv_length_sel_r;
        cfg_word[MODE_LSB +: 2]         = mode_r;
        cfg_word[OVF_BIT]               = overrange_flag_r;
        cfg_word[CRF_BIT]               = conv_done_flag_r;
        cfg_word[FH_BIT]                = above_limit_flag;
        cfg_word[FL_BIT]                = below_limit_flag;
        cfg_word[LATCH_BIT]             = latch_mode_r;
        cfg_word[POL_BIT]               = irq_polarity_r;
        cfg_word[ME_BIT]                = exponent_hide_r;
        cfg_word[FC_LSB +: 2]           = persist_count_r;
    end

    // ------------------------------------------------------------------
    // Overload input synchroniser
    // ------------------------------------------------------------------
    always_ff @(posedge core_clk or posedge sys_rst) begin
        if (sys_rst) begin
            ovl_meta_r <= 1'b0;
            ovl_sync_r <= 1'b0;
        end else begin
            ovl_meta_r <= adc_overload;
            ovl_sync_r <= ovl_meta_r;
        end
    end

    // ------------------------------------------------------------------
    // Writable fields
    // ------------------------------------------------------------------
    always_ff @(posedge core_clk or posedge sys_rst) begin
        if (sys_rst) begin
            range_select_r    <= RANGE_RESET;
            conv_length_sel_r <= CT_RESET;
            latch_mode_r      <= LATCH_RESET;
            irq_polarity_r    <= 1'b0;
            exponent_hide_r   <= 1'b0;
            persist_count_r   <= 2'h0;
        end else if (wr_cfg) begin
            range_select_r    <= reg_wdata[RN_LSB +: 4];
            conv_length_sel_r <= reg_wdata[CT_BIT];
            latch_mode_r      <= reg_wdata[LATCH_BIT];
            irq_polarity_r    <= reg_wdata[POL_BIT];
            exponent_hide_r   <= reg_wdata[ME_BIT];
            persist_count_r   <= reg_wdata[FC_LSB +: 2];
        end
    end

    // Mode field: a write wins; a finished single shot returns it to off.
    always_ff @(posedge core_clk or posedge sys_rst) begin
        if (sys_rst) begin
            mode_r <= MODE_OFF;
        end else if (wr_cfg) begin
            mode_r <= reg_wdata[MODE_LSB +: 2];
        end else if (conv_end && (mode_r == MODE_SINGLE)) begin
            mode_r <= MODE_OFF;
        end
    end

    // ------------------------------------------------------------------
    // Conversion sequencer
    // ------------------------------------------------------------------
    always_ff @(posedge core_clk or posedge sys_rst) begin
        if (sys_rst) begin
            state_r     <= st_off;
            conv_busy_r <= 1'b0;
            cnt_r       <= '0;
        end else if (wr_cfg) begin
            // Any control write restarts timing from zero, aborting a running one.
            cnt_r <= '0;
            if (reg_wdata[MODE_LSB +: 2] != MODE_OFF) begin
                state_r     <= st_conv;
                conv_busy_r <= 1'b1;
            end else begin
                state_r     <= st_off;
                conv_busy_r <= 1'b0;
            end
        end else begin
            unique case (state_r)
                st_off: begin
                    cnt_r <= '0;
                end
                st_conv: begin
                    if (bump || conv_end) begin
                        cnt_r <= '0;
                    end else begin
                        cnt_r <= cnt_r + CNT_W'(1);
                    end
                    if (conv_end && (mode_r == MODE_SINGLE)) begin
                        state_r     <= st_off;
                        conv_busy_r <= 1'b0;
                    end
                end
            endcase
        end
    end

    // Working range: manual code when programmed, else the auto search.
    always_ff @(posedge core_clk or posedge sys_rst) begin
        if (sys_rst) begin
            conv_range_r <= 4'h0;
        end else if (wr_cfg && (reg_wdata[RN_LSB +: 4] < RANGE_AUTO)) begin
            conv_range_r <= reg_wdata[RN_LSB +: 4];
        end else if (bump) begin
            conv_range_r <= conv_range_r + 4'h1;
        end
    end

    // ------------------------------------------------------------------
    // Status flags
    // ------------------------------------------------------------------
    always_ff @(posedge core_clk or posedge sys_rst) begin
        if (sys_rst) begin
            ovl_seen_r       <= 1'b0;
            overrange_flag_r <= 1'b0;
        end else begin
            if (wr_cfg || conv_end || bump) begin
                ovl_seen_r <= 1'b0;
            end else if ((state_r == st_conv) && ovl_sync_r) begin
                ovl_seen_r <= 1'b1;
            end
            if (conv_end) begin
                // Only set after ranging has settled, once per measurement.
                overrange_flag_r <= ovl_seen_r || ovl_sync_r;
            end
        end
    end

    // The end of a conversion beats a clearing read in the same cycle; a control write in that cycle suppresses the end.
    always_ff @(posedge core_clk or posedge sys_rst) begin
        if (sys_rst) begin
            conv_done_flag_r <= 1'b0;
            conv_end_r       <= 1'b0;
        end else begin
            conv_end_r <= conv_end;
            if (conv_end) begin
                conv_done_flag_r <= 1'b1;
            end else if (rd_cfg
                         || (wr_cfg && (reg_wdata[MODE_LSB +: 2] != MODE_OFF))) begin
                conv_done_flag_r <= 1'b0;
            end
        end
    end

    fault_persist u_above (
        .core_clk      (core_clk),
        .sys_rst       (sys_rst),
        .meas_end      (conv_end),
        .exceed        (above_limit_in),
        .persist_count (persist_count_r),
        .hit_r         (above_limit_flag)
    );

    fault_persist u_below (
        .core_clk      (core_clk),
        .sys_rst       (sys_rst),
        .meas_end      (conv_end),
        .exceed        (below_limit_in),
        .persist_count (persist_count_r),
        .hit_r         (below_limit_flag)
    );

    // ------------------------------------------------------------------
    // Read data and result side outputs
    // ------------------------------------------------------------------
    always_ff @(posedge core_clk or posedge sys_rst) begin
        if (sys_rst) begin
            reg_rdata_r <= 16'h0000;
        end else if (reg_rd) begin
            // Other addresses live outside this block and read as zero here.
            reg_rdata_r <= rd_cfg ? cfg_word : 16'h0000;
        end
    end

    always_ff @(posedge core_clk or posedge sys_rst) begin
        if (sys_rst) begin
            result_exp_r <= 4'h0;
            res_loss_r   <= 2'h0;
        end else begin
            // Exponent coding does not depend on conversion length.
            result_exp_r <= (exponent_hide_r && !auto_mode) ? 4'h0
                                                             : conv_range_r;
            if (conv_length_sel_r || (conv_range_r > RANGE_HALF)) begin
                res_loss_r <= 2'h0;
            end else if (conv_range_r == RANGE_HALF) begin
                res_loss_r <= 2'h1;
            end else if (conv_range_r == 4'h0) begin
                res_loss_r <= 2'h3;
            end else begin
                res_loss_r <= 2'h2;
            end
        end
    end

    // ------------------------------------------------------------------
    // Assertions
    // ------------------------------------------------------------------
    default clocking cb @(posedge core_clk); endclocking
    default disable iff (sys_rst);

    sequence s_conv_ends;
        (state_r == st_conv) && !wr_cfg && !bump && (cnt_r == conv_last);
    endsequence

    sequence s_single_done;
        s_conv_ends ##0 (mode_r == MODE_SINGLE);
    endsequence

    property p_read_word;
        rd_cfg |=> (reg_rdata_r == $past(cfg_word));
    endproperty
    a_read_word: assert property (p_read_word) else $error("read data mismatch");

    property p_abort;
        (wr_cfg && (state_r == st_conv)) |=> (cnt_r == '0) ##1 (cnt_r <= CNT_W'(1));
    endproperty
    a_abort: assert property (p_abort) else $error("write did not abort");

    property p_restart;
        (wr_cfg && (reg_wdata[MODE_LSB +: 2] != MODE_OFF))
            |=> (state_r == st_conv) && conv_busy_r;
    endproperty
    a_restart: assert property (p_restart) else $error("no restart after write");

    property p_single_off;
        s_single_done |=> (mode_r == MODE_OFF) && (state_r == st_off) && !conv_busy_r;
    endproperty
    a_single_off: assert property (p_single_off) else $error("single shot not ended");

    property p_done_set;
        s_conv_ends |=> conv_done_flag_r && conv_end_r;
    endproperty
    a_done_set: assert property (p_done_set) else $error("done flag not set");

    property p_off_keeps;
        (wr_cfg && !rd_cfg && (reg_wdata[MODE_LSB +: 2] == MODE_OFF))
            |=> $stable(conv_done_flag_r) && $stable(overrange_flag_r)
                && $stable(above_limit_flag) && $stable(below_limit_flag);
    endproperty
    a_off_keeps: assert property (p_off_keeps) else $error("shutdown changed flags");

    property p_flags_ro;
        (wr_cfg && !conv_end) |=> $stable(overrange_flag_r)
            && $stable(above_limit_flag) && $stable(below_limit_flag);
    endproperty
    a_flags_ro: assert property (p_flags_ro) else $error("write moved overflow");

    property p_bump;
        bump |=> (conv_range_r == $past(conv_range_r) + 4'h1) && (cnt_r == '0);
    endproperty
    a_bump: assert property (p_bump) else $error("auto range not raised");

    property p_res_low;
        (!conv_length_sel_r && (conv_range_r == 4'h0)) |=> (res_loss_r == 2'h3);
    endproperty
    a_res_low: assert property (p_res_low) else $error("resolution loss wrong");

endmodule
`default_nettype wire

// file: test/conv_frontend_model.sv
// Behavioural model of the converter front end that faces the control block.
// Assumes the bench asks for each level; overload arrives off the clock grid.
`timescale 1ns/1ps
`default_nettype none
module conv_frontend_model (
    // Clock
    input  wire logic core_clk,
    // Requests from the bench
    input  wire logic overload_req,
    input  wire logic above_req,
    input  wire logic below_req,
    // Levels towards the block
    output logic      adc_overload,
    output logic      above_limit_in,
    output logic      below_limit_in
);

    initial begin
        adc_overload   = 1'b0;
        above_limit_in = 1'b0;
        below_limit_in = 1'b0;
    end

    // The overload level comes from the analogue side, so it moves between clock edges
    // and the block has to synchronise it.
    always @(overload_req) begin
        adc_overload <= #1.3 overload_req;
    end

    // Comparison levels describe the latest result and change just after a rising edge.
    always @(posedge core_clk) begin
        above_limit_in <= above_req;
        below_limit_in <= below_req;
    end

endmodule
`default_nettype wire

// file: test/testbench.sv
// Self-checking bench of the light sensor operation-control block.
// Assumes shortened conversion counts and the front end model beside it.
`timescale 1ns/1ps
`default_nettype none
module testbench;
    import light_cfg_pkg::*;

    // ------------------------------------------------------------------
    // Signals and instances
    // ------------------------------------------------------------------
    localparam int SHORT = 20;
    localparam int LONG  = 40;
    logic        core_clk  = 1'b0;
    logic        sys_rst   = 1'b1;
    logic [7:0]  reg_addr  = 8'h00;
    logic        reg_wr    = 1'b0;
    logic        reg_rd    = 1'b0;
    logic [15:0] reg_wdata = 16'h0000;
    logic [15:0] reg_rdata_r;
    logic        ovl_req   = 1'b0;
    logic        above_req = 1'b0;
    logic        below_req = 1'b0;
    logic        adc_overload;
    logic        above_limit_in;
    logic        below_limit_in;
    logic        conv_busy_r;
    logic        conv_end_r;
    logic [3:0]  conv_range_r;
    logic [3:0]  result_exp_r;
    logic [1:0]  res_loss_r;
    logic        latch_mode_r;
    logic        irq_polarity_r;
    int          n_errors  = 0;
    int          tests_run = 0;
    int          k;

    always #2 core_clk = ~core_clk;

    light_cfg_ctrl #(.SHORT_CYC(SHORT), .LONG_CYC(LONG)) uut (
        .core_clk       (core_clk),
        .sys_rst        (sys_rst),
        .reg_addr       (reg_addr),
        .reg_wr         (reg_wr),
        .reg_rd         (reg_rd),
        .reg_wdata      (reg_wdata),
        .reg_rdata_r    (reg_rdata_r),
        .adc_overload   (adc_overload),
        .above_limit_in (above_limit_in),
        .below_limit_in (below_limit_in),
        .conv_busy_r    (conv_busy_r),
        .conv_end_r     (conv_end_r),
        .conv_range_r   (conv_range_r),
        .result_exp_r   (result_exp_r),
        .res_loss_r     (res_loss_r),
        .latch_mode_r   (latch_mode_r),
        .irq_polarity_r (irq_polarity_r)
    );

    conv_frontend_model fe (
        .core_clk       (core_clk),
        .overload_req   (ovl_req),
        .above_req      (above_req),
        .below_req      (below_req),
        .adc_overload   (adc_overload),
        .above_limit_in (above_limit_in),
        .below_limit_in (below_limit_in)
    );

    // ------------------------------------------------------------------
    // Access and checking tasks
    // ------------------------------------------------------------------
    task automatic end_sim();
        $display("comparisons %0d, mismatches %0d", tests_run, n_errors);
        if (n_errors == 0 && tests_run > 0) begin
            $display("No errors found");
        end else begin
            $display("Errors were found");
        end
        $finish;
    endtask

    task automatic check(input logic [15:0] seen, input logic [15:0] exp);
        tests_run++;
        if (seen !== exp) begin
            n_errors++;
            $display("[ERR] t=%0t seen=%h exp=%h", $time, seen, exp);
        end
    endtask

    // Both access tasks end one idle cycle later, so strobes never re-arm in one step.
    task automatic wr(input logic [7:0] a, input logic [15:0] d);
        reg_addr  = a;
        reg_wdata = d;
        reg_wr    = 1'b1;
        @(negedge core_clk);
        reg_wr = 1'b0;
        @(negedge core_clk);
    endtask

    task automatic rd(input logic [7:0] a, input logic [15:0] exp);
        reg_addr = a;
        reg_rd   = 1'b1;
        @(negedge core_clk);
        reg_rd = 1'b0;
        @(negedge core_clk);
        check(reg_rdata_r, exp);
    endtask

    // Waits for the end pulse and checks that it came within lo..hi cycles.
    task automatic expect_end(input int lo, input int hi);
        int n;
        n = 0;
        do begin
            @(negedge core_clk);
            n++;
        end while (conv_end_r !== 1'b1 && n < hi + 5);
        if (conv_end_r !== 1'b1) begin
            n_errors++;
            $display("[ERR] t=%0t seen=%h exp=%h", $time, 1'b0, 1'b1);
            end_sim();
        end
        check(16'(n >= lo && n <= hi), 16'h0001);
    endtask

    function automatic logic [15:0] loss_of(input int r);
        return (r == 0) ? 16'h0003 : (r <= 4) ? 16'h0002 : (r == 5) ? 16'h0001 : 16'h0000;
    endfunction

    // ------------------------------------------------------------------
    // Main sequence
    // ------------------------------------------------------------------
    initial begin
        repeat (12) @(negedge core_clk);
        sys_rst = 1'b0;
        check({15'h0, latch_mode_r}, 16'h0001);
        rd(CFG_ADDR, CFG_RESET);
        check({15'h0, conv_busy_r}, 16'h0000);
        wr(CFG_ADDR, 16'h01ff);
        rd(CFG_ADDR, 16'h001f);
        check({15'h0, irq_polarity_r}, 16'h0001);
        wr(8'h02, 16'hffff);
        rd(8'h02, 16'h0000);
        rd(CFG_ADDR, 16'h001f);
        for (int r = 0; r < 12; r++) begin
            wr(CFG_ADDR, {r[3:0], 12'h010});
            @(negedge core_clk);
            check({14'h0, res_loss_r}, loss_of(r));
            check({12'h0, result_exp_r}, 16'(r));
        end
        wr(CFG_ADDR, 16'h3014);
        @(negedge core_clk);
        check({12'h0, result_exp_r}, 16'h0000);
        wr(CFG_ADDR, 16'h3810);
        @(negedge core_clk);
        check({14'h0, res_loss_r}, 16'h0000);
        check({12'h0, result_exp_r}, 16'h0003);
        // Single shot, short conversion, manual range 0.
        wr(CFG_ADDR, 16'h0210);
        check({15'h0, conv_busy_r}, 16'h0001);
        rd(CFG_ADDR, 16'h0210);
        expect_end(SHORT - 6, SHORT + 3);
        check({15'h0, conv_busy_r}, 16'h0000);
        wr(CFG_ADDR, 16'h0010);
        rd(CFG_ADDR, 16'h0090);
        rd(CFG_ADDR, 16'h0010);
        // A rewrite mid-conversion restarts the long count from the new write.
        wr(CFG_ADDR, 16'h0a10);
        repeat (10) @(negedge core_clk);
        wr(CFG_ADDR, 16'h0a10);
        expect_end(LONG - 2, LONG + 3);
        wr(CFG_ADDR, 16'h0a10);
        repeat (5) @(negedge core_clk);
        wr(CFG_ADDR, 16'h0010);
        k = 0;
        repeat (LONG + 10) begin
            @(negedge core_clk);
            if (conv_end_r !== 1'b0) k++;
        end
        check(16'(k), 16'h0000);
        check({15'h0, conv_busy_r}, 16'h0000);
        // Both continuous codes run back to back.
        for (int m = 2; m < 4; m++) begin
            wr(CFG_ADDR, {4'h0, 1'b0, m[1:0], 9'h010});
            expect_end(SHORT - 2, SHORT + 3);
            expect_end(SHORT - 1, SHORT + 1);
            rd(CFG_ADDR, {4'h0, 1'b0, m[1:0], 9'h090});
        end
        // Limit flags: two exceeding results needed, then one clears it.
        above_req = 1'b1;
        wr(CFG_ADDR, 16'h0411);
        expect_end(SHORT - 2, SHORT + 3);
        rd(CFG_ADDR, 16'h0491);
        expect_end(SHORT - 6, SHORT + 1);
        rd(CFG_ADDR, 16'h04d1);
        above_req = 1'b0;
        below_req = 1'b1;
        wr(CFG_ADDR, 16'h0410);
        expect_end(SHORT - 2, SHORT + 3);
        rd(CFG_ADDR, 16'h04b0);
        below_req = 1'b0;
        wr(CFG_ADDR, 16'h0010);
        // Automatic range under steady overload climbs to the top range.
        // Only code 1100b is used for automatic ranging; the codes above it stay unwritten.
        ovl_req = 1'b1;
        wr(CFG_ADDR, 16'hc210);
        expect_end(SHORT - 2, SHORT + 80);
        check({12'h0, conv_range_r}, 16'h000b);
        check({12'h0, result_exp_r}, 16'h000b);
        rd(CFG_ADDR, 16'hc190);
        ovl_req = 1'b0;
        // A reset after the finished single shot must drop the overflow flag and the working range.
        sys_rst = 1'b1;
        repeat (12) @(negedge core_clk);
        sys_rst = 1'b0;
        check({12'h0, conv_range_r}, 16'h0000);
        rd(CFG_ADDR, CFG_RESET);
        end_sim();
    end

endmodule
`default_nettype wire
